// *** dv/port_breaker_model.sv ***
// Far-side port breaker model that raises overcurrent flags
`timescale 1ns/1ps
`default_nettype none
module port_breaker_model (
    input  wire logic       clk_i,             // System clock
    input  wire logic [5:0] power_en_i,        // Port power from the manager
    input  wire logic [5:0] fault_i,           // Overload ordered by the bench
    output logic      [5:0] overcurrent_o = '0 // Breaker flags, high = overload
);
    // An unpowered port draws nothing, so its breaker never trips
    always_ff @(posedge clk_i) begin
        overcurrent_o <= power_en_i & fault_i;
    end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Bench for the port power manager: APB sequences with expected values
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import port_power_pkg::*;
;
    logic        clk_i = 0, reset_n_i = 0, slverr;   // Clock, reset, error seen
    logic        psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [7:0]  paddr_i = 0;                        // APB address
    logic [31:0] pwdata_i = 0, prdata_o, rdata;      // APB data
    logic        pready_o, pslverr_o, host_notify_o;
    logic        host_attached_i = 1, ext_supply_i = 1, up_link_i = 1;
    logic [5:0]  boot_enable_i = 6'h03, par_ctrl_i = 6'h3f, fault = 0;
    logic [5:0]  load_sense_i = 0, normal_dev_i = 0, charge_done_i = 0;
    logic [5:0]  profile_ok_i = 0, port_link_i = 0, overcurrent_i;
    logic [5:0]  power_en_o, data_en_o, detect_en_o; // Port outputs
    logic [11:0] charge_sig_o, profile_o;
    logic [17:0] limit_code_o, indicator_o;
    logic [71:0] current_i = 0;                      // Six port currents
    logic [1:0]  prof_seen;                          // Emulation profile seen
    int          errors = 0, checked = 0;

    port_power_manager #(.DWELL_CYCLES(8)) i_dut (.clk_i, .reset_n_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .boot_enable_i, .host_attached_i, .ext_supply_i, .par_ctrl_i, .overcurrent_i,
        .load_sense_i, .normal_dev_i, .port_link_i, .up_link_i, .charge_done_i,
        .profile_ok_i, .current_i, .power_en_o, .data_en_o, .charge_sig_o, .profile_o,
        .limit_code_o, .detect_en_o, .indicator_o, .host_notify_o);
    port_breaker_model i_breaker (.clk_i, .power_en_i(power_en_o), .fault_i(fault),
        .overcurrent_o(overcurrent_i));

    // Free-running 20 MHz clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // One compare, reported at once on mismatch
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // APB transfer; request held until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            @(posedge clk_i);
            if (pready_o === 1'b1) begin
                {rdata, slverr} = {prdata_o, pslverr_o};
                {psel_i, penable_i} <= 2'b00;
                return;
            end
        end
        errors++;
        complete_run();
    endtask

    // Let sync stages and power registers settle
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Hang guard, well under 100k cycles
    initial begin
        #2_000_000;
        errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        idle(8);
        reset_n_i <= 1'b1;
        idle(6);
        cmp(power_en_o, 6'h03);
        for (int i = 0; i < 2; i++) begin
            port_link_i <= i ? 6'h2a : 6'h05;
            up_link_i <= (i == 0);
            current_i <= {60'h0, i ? 12'h02f : 12'h010};
            idle(2);
            xfer(0, REG_STATUS, 0);
            cmp(rdata & 32'h7f00_0000, {1'b0, i == 0, i ? 6'h2a : 6'h05, 24'h0});
            xfer(0, REG_CURRENT0, 0);
            cmp(rdata, i ? 32'h02f : 32'h010);
        end
        xfer(0, 8'h18, 0);
        cmp({rdata[30:0], slverr}, 1);
        xfer(1, REG_LIMIT, 32'h6d);
        xfer(0, REG_STATUS, 0);
        cmp({rdata[31], limit_code_o[2:0]}, 4'h9);
        xfer(1, REG_LIMIT, 32'h6);
        xfer(0, REG_STATUS, 0);
        cmp({rdata[31], limit_code_o[2:0]}, 4'h9);
        xfer(1, REG_LIMIT, 32'h924d);
        xfer(0, REG_STATUS, 0);
        cmp({rdata[31], limit_code_o[2:0]}, {1'b0, LIM_MAX});
        xfer(1, REG_ENABLE, 32'h3f);
        xfer(1, REG_OPTION, 32'h200);
        fault <= 6'h30;
        idle(8);
        cmp(host_notify_o, 0);
        fault <= 6'h32;
        idle(8);
        cmp(host_notify_o, 0);
        fault <= 6'h33;
        idle(8);
        cmp(host_notify_o, 1);
        fault <= 6'h00;
        idle(4);
        xfer(0, REG_STATUS, 0);
        cmp(rdata & 32'h3f3f, 32'h330c);
        xfer(1, REG_ENABLE, 32'h0c);
        xfer(1, REG_ENABLE, 32'h3f);
        idle(6);
        xfer(0, REG_STATUS, 0);
        cmp(rdata & 32'h3f3f, 32'h003f);
        xfer(1, REG_MODE, 32'hc60);
        idle(1);
        cmp(charge_sig_o, {SIG_EMU, SIG_NONE, SIG_CDP, SIG_DCP, 4'h0});
        cmp({data_en_o & 6'h24, limit_code_o[17:15]}, LIM_MAX);
        host_attached_i <= 1'b0;
        idle(6);
        cmp(power_en_o, 6'h24);
        host_attached_i <= 1'b1;
        idle(6);
        cmp(power_en_o, 6'h3f);
        prof_seen = profile_o[11:10];
        idle(8);
        cmp(profile_o[11:10], 2'(prof_seen + 1));
        profile_ok_i <= 6'h20;
        idle(2);
        prof_seen = profile_o[11:10];
        idle(9);
        xfer(0, REG_CHARGE, 0);
        cmp({rdata[13:8], profile_o[11:10]}, {6'h20, prof_seen});
        load_sense_i <= 6'h0d;
        charge_done_i <= 6'h04;
        idle(4);
        cmp(indicator_o, {IND_NO_DEVICE, IND_NO_DEVICE, IND_CHARGING, IND_CHARGED,
                          IND_NO_DEVICE, IND_ON});
        load_sense_i <= 6'h00;
        idle(4);
        xfer(0, REG_STATUS, 0);
        cmp(rdata[21:16], 6'h08);
        normal_dev_i <= 6'h08;
        idle(2);
        xfer(0, REG_STATUS, 0);
        cmp(rdata[21:16], 6'h00);
        xfer(1, REG_OPTION, 32'h0101_0201);
        idle(6);
        cmp({power_en_o[0], detect_en_o[1:0]}, 3'b010);
        cmp(indicator_o[2:0], IND_OFF);
        par_ctrl_i <= 6'h3e;
        idle(6);
        cmp(power_en_o[0], 1);
        current_i <= {48'h0, 12'h032, 12'h02f};
        idle(2);
        cmp(power_en_o[1], 1);
        current_i <= {48'h0, 12'h033, 12'h02f};
        idle(2);
        cmp(power_en_o[1], 0);
        complete_run();
    end
endmodule
`default_nettype wire

// *** rtl/port_power_manager.sv ***
// Six-port downstream power, mode and overcurrent manager with APB registers
//
// Contract
// - Six ports, each with four modes
// - Standard port trips off above threshold
// - Charge-capable port signals CDP status
// - Dedicated port signals DCP, max limit, no data
// - Emulation steps profiles, max limit, no data
// - Charging-only ports powered hostless with supply
// - Attach detect per port, can be disabled
// - CDP attach flag cleared by device or recycle
// - Report port current in 10 mA units
// - Threshold in 500 mA steps, max 2500
// - Reject threshold sum above 5000 mA
// - Overcurrent turns port off, notifies host
// - Per-port notify suppression keeps shutoff
// - Ports five and six never notify
// - Parallel inputs pulled high, low changes
// - Per-port parallel input polarity
// - Per-port priority parallel versus USB
// - Report USB 2.0 link per port and upstream
// - Indicator off/nodev/on/charging/charged states
// - Power-on port set from non-volatile store
// - No host: ports off except charging ports
`timescale 1ns/1ps
`default_nettype none

module port_power_manager
    import port_power_pkg::*;
#(
    parameter int unsigned DWELL_CYCLES = PROFILE_CYCLES  // Emulation profile dwell
) (
    input  wire logic                     clk_i,
    input  wire logic                     reset_n_i,
    // APB slave
    input  wire logic                     psel_i,
    input  wire logic                     penable_i,
    input  wire logic                     pwrite_i,
    input  wire logic [7:0]               paddr_i,
    input  wire logic [31:0]              pwdata_i,
    output logic      [31:0]              prdata_o,
    output logic                          pready_o,
    output logic                          pslverr_o,
    // Stored power-on configuration
    input  wire logic [NUM_PORTS-1:0]     boot_enable_i,
    // System state, pins
    input  wire logic                     host_attached_i,
    input  wire logic                     ext_supply_i,
    input  wire logic [NUM_PORTS-1:0]     par_ctrl_i,
    input  wire logic [NUM_PORTS-1:0]     overcurrent_i,
    input  wire logic [NUM_PORTS-1:0]     load_sense_i,
    input  wire logic [NUM_PORTS-1:0]     normal_dev_i,
    input  wire logic [NUM_PORTS-1:0]     port_link_i,
    input  wire logic                     up_link_i,
    input  wire logic [NUM_PORTS-1:0]     charge_done_i,
    input  wire logic [NUM_PORTS-1:0]     profile_ok_i,
    // Per-port current samples, 10 mA units, from the measuring logic
    input  wire logic [NUM_PORTS*CUR_W-1:0] current_i,
    // Port outputs
    output logic      [NUM_PORTS-1:0]     power_en_o,
    output logic      [NUM_PORTS-1:0]     data_en_o,
    output logic      [NUM_PORTS*2-1:0]   charge_sig_o,
    output logic      [NUM_PORTS*PROF_W-1:0] profile_o,
    output logic      [NUM_PORTS*LIM_W-1:0]  limit_code_o,
    output logic      [NUM_PORTS-1:0]     detect_en_o,
    output logic      [NUM_PORTS*3-1:0]   indicator_o,
    output logic                          host_notify_o
);

    localparam logic [7:0] WORD_STEP = 8'h04;  // Byte stride between current words
    localparam logic [LIM_W-1:0] LIM_RESET = 3'h1; // 500 mA on every port

    // Limit code sum, used by write check
    function automatic logic [7:0] limit_sum(input logic [31:0] w);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < NUM_PORTS; i++) begin
            s = s + {5'h00, w[i*LIM_W +: LIM_W]};
        end
        return s;
    endfunction

    // Any code above the 2500 mA ceiling
    function automatic logic limit_bad(input logic [31:0] w);
        logic b;
        b = 1'b0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            b = b | (w[i*LIM_W +: LIM_W] > LIM_MAX);
        end
        return b;
    endfunction

    // Pin synchronisers, two stages
    logic [NUM_PORTS-1:0] par_s1, par_s2;     // Parallel control
    logic [NUM_PORTS-1:0] oc_s1, oc_s2;       // Overcurrent flag
    logic [NUM_PORTS-1:0] ld_s1, ld_s2;       // Load sense
    logic [1:0]           sys_s1, sys_s2;     // Host, supply
    // Parallel inputs are pulled high on board; only low differs from open
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            par_s1 <= '1;
            par_s2 <= '1;
            oc_s1  <= '0;
            oc_s2  <= '0;
            ld_s1  <= '0;
            ld_s2  <= '0;
            sys_s1 <= '0;
            sys_s2 <= '0;
        end else begin
            par_s1 <= par_ctrl_i;
            par_s2 <= par_s1;
            oc_s1  <= overcurrent_i;
            oc_s2  <= oc_s1;
            ld_s1  <= load_sense_i;
            ld_s2  <= ld_s1;
            sys_s1 <= {ext_supply_i, host_attached_i};
            sys_s2 <= sys_s1;
        end
    end

    wire logic host_ok   = sys_s2[0];
    wire logic supply_ok = sys_s2[1];

    // Register state
    logic [NUM_PORTS-1:0]       cmd_on, next_cmd_on;        // USB on command
    logic [NUM_PORTS*2-1:0]     mode, next_mode;            // Mode per port
    logic [NUM_PORTS*LIM_W-1:0] limit, next_limit;          // Threshold codes
    logic [31:0]                option, next_option;        // Option word
    logic                       lim_err, next_lim_err;      // Last limit write rejected
    logic                       boot_load, next_boot_load;  // Store not yet applied
    // Per-port state
    logic [NUM_PORTS-1:0]       trip, next_trip;            // Overcurrent latch
    logic [NUM_PORTS-1:0]       attach, next_attach;        // Attach flag
    logic [NUM_PORTS-1:0]       pwr_q, next_pwr;            // Port power

    wire logic wr_en = psel_i && penable_i && pwrite_i;
    wire logic [NUM_PORTS-1:0] off_cmd = wr_en && (paddr_i == REG_ENABLE)
                                         ? ~pwdata_i[NUM_PORTS-1:0] : '0;

    // Effective on request per port: parallel or USB, hostless charging
    logic [NUM_PORTS-1:0] want_on;
    logic [NUM_PORTS-1:0] charger_only;
    logic [NUM_PORTS-1:0] over_lim;
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            logic par_on;
            logic chg;
            par_on = par_s2[p] ^ option[OPT_POL_LOW + p];
            chg    = mode[p*2 +: 2] == MODE_DEDICATED || mode[p*2 +: 2] == MODE_EMULATE;
            charger_only[p] = chg;
            // Parallel input wins where its priority bit is set
            want_on[p] = option[OPT_PAR_PRI + p] ? par_on : cmd_on[p];
            // Hostless: only charging ports with a supply stay up
            if (!host_ok) begin
                want_on[p] = want_on[p] && chg && supply_ok;
            end
            // Trip from the breaker flag or from measured current
            over_lim[p] = oc_s2[p] || (current_i[p*CUR_W +: CUR_W] >
                          12'(STEP_IN_LSB * limit[p*LIM_W +: LIM_W]));
        end
    end

    // Register next state
    always_comb begin
        next_cmd_on    = cmd_on;
        next_mode      = mode;
        next_limit     = limit;
        next_option    = option;
        next_lim_err   = lim_err;
        next_boot_load = 1'b0;
        // Stored start-up set applied once after reset
        if (boot_load) begin
            next_cmd_on = boot_enable_i;
        end else if (wr_en) begin
            case (paddr_i)
                REG_ENABLE: next_cmd_on = pwdata_i[NUM_PORTS-1:0];
                REG_MODE:   next_mode   = pwdata_i[NUM_PORTS*2-1:0];
                REG_LIMIT: begin
                    // Whole set is rejected if any code or the sum is too big
                    if (limit_bad(pwdata_i) || limit_sum(pwdata_i) > BUDGET_MAX) begin
                        next_lim_err = 1'b1;
                    end else begin
                        next_limit   = pwdata_i[NUM_PORTS*LIM_W-1:0];
                        next_lim_err = 1'b0;
                    end
                end
                REG_OPTION: next_option = pwdata_i;
                default: ;
            endcase
        end
    end

    // Register storage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_on    <= '0;
            mode      <= '0;
            limit     <= {NUM_PORTS{LIM_RESET}};
            option    <= '0;
            lim_err   <= 1'b0;
            boot_load <= 1'b1;
        end else begin
            cmd_on    <= next_cmd_on;
            mode      <= next_mode;
            limit     <= next_limit;
            option    <= next_option;
            lim_err   <= next_lim_err;
            boot_load <= next_boot_load;
        end
    end

    // Per-port next state: trip latch, attach, power
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            next_trip[p]   = trip[p];
            next_attach[p] = attach[p];
            // Off command clears the latch; a trip in that cycle still wins
            if (off_cmd[p] || !want_on[p]) begin
                next_trip[p] = 1'b0;
            end
            if (pwr_q[p] && over_lim[p]) begin
                next_trip[p] = 1'b1;
            end
            next_pwr[p] = want_on[p] && !next_trip[p];
            // Detection disabled: flag forced clear
            if (option[OPT_DET_OFF + p] || !pwr_q[p]) begin
                next_attach[p] = 1'b0;
            end else if (ld_s2[p]) begin
                next_attach[p] = 1'b1;
            end else if (mode[p*2 +: 2] != MODE_CHARGE_CAP || normal_dev_i[p]) begin
                // CDP may keep a stale flag until a normal device appears
                next_attach[p] = 1'b0;
            end
        end
    end

    // Per-port storage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            trip   <= '0;
            attach <= '0;
            pwr_q  <= '0;
        end else begin
            trip   <= next_trip;
            attach <= next_attach;
            pwr_q  <= next_pwr;
        end
    end

    // Emulation profile stepping, one counter and index per port
    logic [31:0]                 dwell [NUM_PORTS];
    logic [31:0]                 next_dwell [NUM_PORTS];
    logic [NUM_PORTS*PROF_W-1:0] prof, next_prof;
    logic [NUM_PORTS-1:0]        prof_lock, next_prof_lock;
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            next_dwell[p]              = dwell[p];
            next_prof[p*PROF_W +: PROF_W] = prof[p*PROF_W +: PROF_W];
            next_prof_lock[p]          = prof_lock[p];
            if (!pwr_q[p] || mode[p*2 +: 2] != MODE_EMULATE) begin
                // Restart the search whenever the port leaves emulation
                next_dwell[p]     = '0;
                next_prof[p*PROF_W +: PROF_W] = '0;
                next_prof_lock[p] = 1'b0;
            end else if (!prof_lock[p]) begin
                if (profile_ok_i[p]) begin
                    next_prof_lock[p] = 1'b1;
                end else if (dwell[p] == DWELL_CYCLES - 1) begin
                    next_dwell[p] = '0;
                    next_prof[p*PROF_W +: PROF_W] =
                        prof[p*PROF_W +: PROF_W] + 2'(1);
                end else begin
                    next_dwell[p] = dwell[p] + 32'd1;
                end
            end
        end
    end

    // Profile storage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                dwell[p] <= '0;
            end
            prof      <= '0;
            prof_lock <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                dwell[p] <= next_dwell[p];
            end
            prof      <= next_prof;
            prof_lock <= next_prof_lock;
        end
    end

    // Port drive outputs
    generate
        for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
            wire port_mode_e m = port_mode_e'(mode[g*2 +: 2]);
            // Charging modes cut data and force the top limit
            assign data_en_o[g] = pwr_q[g] && !charger_only[g];
            assign limit_code_o[g*LIM_W +: LIM_W] =
                charger_only[g] ? LIM_MAX : limit[g*LIM_W +: LIM_W];
            assign charge_sig_o[g*2 +: 2] = !pwr_q[g] ? SIG_NONE :
                (m == MODE_CHARGE_CAP) ? SIG_CDP :
                (m == MODE_DEDICATED)  ? SIG_DCP :
                (m == MODE_EMULATE)    ? SIG_EMU : SIG_NONE;
            assign profile_o[g*PROF_W +: PROF_W] = prof[g*PROF_W +: PROF_W];
            assign detect_en_o[g] = pwr_q[g] && !option[OPT_DET_OFF + g];
            // Indicator: charge states only away from standard mode
            assign indicator_o[g*3 +: 3] = !pwr_q[g] ? IND_OFF :
                (m != MODE_STANDARD && attach[g]) ?
                    (charge_done_i[g] ? IND_CHARGED : IND_CHARGING) :
                (!attach[g] && !option[OPT_DET_OFF + g]) ? IND_NO_DEVICE :
                IND_ON;
        end
    endgenerate
    assign power_en_o = pwr_q;

    // Host notification only for ports one to four without suppression
    logic notify_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            notify_q <= 1'b0;
        end else begin
            notify_q <= |(trip[NOTIFY_PORTS-1:0]
                         & ~option[OPT_NTF_OFF +: NOTIFY_PORTS]);
        end
    end
    assign host_notify_o = notify_q;

    // APB read mux; zero wait state, unmapped reads zero with error
    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        case (paddr_i)
            REG_ENABLE: rd_word[NUM_PORTS-1:0]       = cmd_on;
            REG_MODE:   rd_word[NUM_PORTS*2-1:0]     = mode;
            REG_LIMIT:  rd_word[NUM_PORTS*LIM_W-1:0] = limit;
            REG_OPTION: rd_word = option;
            REG_STATUS: begin
                rd_word[ST_POWER  +: NUM_PORTS] = pwr_q;
                rd_word[ST_TRIP   +: NUM_PORTS] = trip;
                rd_word[ST_ATTACH +: NUM_PORTS] = attach;
                rd_word[ST_LINK   +: NUM_PORTS] = port_link_i;
                rd_word[ST_UPLINK]              = up_link_i;
                rd_word[ST_LIMERR]              = lim_err;
            end
            REG_CHARGE: begin
                rd_word[NUM_PORTS-1:0]         = charge_done_i;
                rd_word[8 +: NUM_PORTS]        = prof_lock;
                rd_word[16 +: NUM_PORTS*PROF_W] = prof;
            end
            default: begin
                rd_hit = 1'b0;
                for (int p = 0; p < NUM_PORTS; p++) begin
                    if (paddr_i == REG_CURRENT0 + 8'(p) * WORD_STEP) begin
                        rd_word[CUR_W-1:0] = current_i[p*CUR_W +: CUR_W];
                        rd_hit = 1'b1;
                    end
                end
            end
        endcase
    end

    assign pready_o  = 1'b1;
    assign prdata_o  = (psel_i && !pwrite_i) ? rd_word : 32'h0;
    assign pslverr_o = psel_i && penable_i && !rd_hit;

    // Assertions
    a_trip_kills_power: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        trip != 0 |-> (power_en_o & trip) == 0) else $error("Tripped port powered");
    a_trip_sets_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (pwr_q[0] && oc_s2[0]) |=> trip[0]) else $error("Trip not latched");
    a_high_ports_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        trip[5:4] != 0 && trip[3:0] == 0 |=> !host_notify_o)
        else $error("Port five or six notified");
    a_notify_follows: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (trip[0] && !option[OPT_NTF_OFF]) |=> host_notify_o)
        else $error("Notify missing");
    a_budget_reject: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (wr_en && paddr_i == REG_LIMIT && !boot_load
         && limit_sum(pwdata_i) > BUDGET_MAX) |=> lim_err && $stable(limit))
        else $error("Over-budget limits applied");
    a_hostless_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !host_ok && $past(!host_ok) |-> (power_en_o & ~charger_only) == 0)
        else $error("Port powered without host");
    a_charge_no_data: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (data_en_o & charger_only) == 0) else $error("Data on charging port");
    a_detect_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        option[OPT_DET_OFF] |=> !attach[0]) else $error("Attach with detect off");
    a_boot_apply: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $fell(boot_load) |-> cmd_on == $past(boot_enable_i)) else $error("Boot set lost");

endmodule

`default_nettype wire

// *** rtl/port_power_pkg.sv ***
// Package for the six-port power manager: register map, fields, modes, timing
package port_power_pkg;

    localparam int unsigned NUM_PORTS    = 6;              // Downstream ports
    localparam int unsigned NOTIFY_PORTS = 4;              // Ports that may notify the host
    localparam int unsigned CUR_W        = 12;             // Current reading width, 10 mA units
    localparam int unsigned LIM_W        = 3;              // Limit code width, 500 mA steps
    localparam int unsigned LIM_STEP_MA  = 500;            // Limit step in mA
    localparam logic [LIM_W-1:0] LIM_MAX = 3'h5;           // Code 5 = 2500 mA
    localparam logic [7:0] BUDGET_MAX    = 8'h0a;          // 10 steps = 5000 mA total
    localparam logic [CUR_W-1:0] STEP_IN_LSB = 12'h032;    // 500 mA in 10 mA counts

    // Charger emulation profile dwell, 200 ms at 20 MHz
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned PROFILE_DWELL_MS = 200;
    localparam int unsigned PROFILE_CYCLES  = CLK_HZ / 1000 * PROFILE_DWELL_MS;
    localparam int unsigned NUM_PROFILES    = 4;           // Signature profiles tried
    localparam int unsigned PROF_W          = 2;

    // Register byte offsets
    localparam logic [7:0] REG_ENABLE   = 8'h00; // Bit n: port on command
    localparam logic [7:0] REG_MODE     = 8'h04; // 2 bits per port
    localparam logic [7:0] REG_LIMIT    = 8'h08; // 3 bits per port; write all at once
    localparam logic [7:0] REG_OPTION   = 8'h0c; // Detect off, notify off, polarity, priority
    localparam logic [7:0] REG_STATUS   = 8'h10; // Power, trip, attach, link, error
    localparam logic [7:0] REG_CHARGE   = 8'h14; // Charge done, profile accepted, profile index
    localparam logic [7:0] REG_CURRENT0 = 8'h20; // Six words of port current

    // Option field positions
    localparam int unsigned OPT_DET_OFF = 0;
    localparam int unsigned OPT_NTF_OFF = 8;
    localparam int unsigned OPT_POL_LOW = 16;
    localparam int unsigned OPT_PAR_PRI = 24;
    // Status field positions
    localparam int unsigned ST_POWER  = 0;
    localparam int unsigned ST_TRIP   = 8;
    localparam int unsigned ST_ATTACH = 16;
    localparam int unsigned ST_LINK   = 24;
    localparam int unsigned ST_UPLINK = 30;
    localparam int unsigned ST_LIMERR = 31;

    // Port modes
    typedef enum logic [1:0] {
        MODE_STANDARD = 2'b00,
        MODE_CHARGE_CAP = 2'b01,
        MODE_DEDICATED = 2'b10,
        MODE_EMULATE = 2'b11
    } port_mode_e;

    // Indicator codes
    typedef enum logic [2:0] {
        IND_OFF       = 3'b000,
        IND_NO_DEVICE = 3'b001,
        IND_ON        = 3'b010,
        IND_CHARGING  = 3'b011,
        IND_CHARGED   = 3'b100
    } indicator_e;

    // Charge signalling codes driven to the port data-line switch
    localparam logic [1:0] SIG_NONE = 2'b00;
    localparam logic [1:0] SIG_CDP  = 2'b01;
    localparam logic [1:0] SIG_DCP  = 2'b10;
    localparam logic [1:0] SIG_EMU  = 2'b11;

endpackage
